/* pcl_cfg_device.sv */
// device end of the fast parallel configuration port
// assumes the host keeps each word stable for a full ratio interval
`timescale 1ns/10ps
`include "pcl_defs.svh"
module pcl_cfg_device #(
	parameter int ImageWords = `PCL_IMAGE_WORDS,
	parameter int PorShortCycles = `PCL_POR_SHORT_US * `PCL_CLK_MHZ,
	parameter int PorLongCycles = `PCL_POR_LONG_US * `PCL_CLK_MHZ,
	parameter int InitCycles = `PCL_INIT_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	pcl_link_if.device link,
	input wire logic [2:0] modeSelectPins,
	input wire logic decompressEn,
	input wire logic securityEn,
	input wire logic userPinsDrive,
	input wire logic [31:0] userDataOut,
	output logic [31:0] cfgWord,
	output logic cfgWordValid,
	output logic userMode
);
	localparam int CntW = $clog2(ImageWords + 1);

	////////////////////////////////////////////////////////////////////
	// pin synchronisation and clock edges

	logic [33:0] pinSync;
	logic cclkSync;
	logic reqNSync;
	logic [31:0] dataSync;
	logic cclkPrev_r;
	logic cclkRise;
	logic cclkFall;

	pcl_sync #(.Width(34)) uPinSync (
		.clk(clk),
		.rst(rst),
		.din({link.configClock, link.configRequestN, link.data}),
		.dout(pinSync)
	);

	assign cclkSync = pinSync[33];
	assign reqNSync = pinSync[32];
	assign dataSync = pinSync[31:0];

	always_ff @(posedge clk) begin
		if (rst) begin
			cclkPrev_r <= 1'b0;
		end else begin
			cclkPrev_r <= cclkSync;
		end
	end

	assign cclkRise = cclkSync && !cclkPrev_r;
	assign cclkFall = !cclkSync && cclkPrev_r;

	////////////////////////////////////////////////////////////////////
	// state

	pcl_pkg::pcl_dev_state_t state_r, state_nxt;
	pcl_pkg::pcl_width_t width_r, width_nxt;
	logic [31:0] porCnt_r, porCnt_nxt;
	logic [3:0] ratio_r, ratio_nxt;
	logic [2:0] phase_r, phase_nxt;
	logic [CntW-1:0] wordCnt_r, wordCnt_nxt;
	logic [CntW-1:0] cntAfter;
	logic [1:0] fallCnt_r, fallCnt_nxt;
	logic [7:0] initCnt_r, initCnt_nxt;
	logic statusLowOe_r, statusLowOe_nxt;
	logic loadComplete_r, loadComplete_nxt;
	logic initDoneLowOe_r, initDoneLowOe_nxt;
	logic devDataOe_r, devDataOe_nxt;
	logic [31:0] devData_r, devData_nxt;
	logic [31:0] cfgWord_r, cfgWord_nxt;
	logic cfgWordValid_r, cfgWordValid_nxt;
	logic userMode_r, userMode_nxt;
	logic [31:0] laneMask;
	logic takeWord;
	always_comb begin
		case (width_r)
			pcl_pkg::W8: laneMask = 32'h0000_00ff;
			pcl_pkg::W16: laneMask = 32'h0000_ffff;
			default: laneMask = 32'hffff_ffff;
		endcase
	end

	assign takeWord = cclkRise && phase_r == 3'h0;
	assign cntAfter = takeWord ? CntW'(wordCnt_r + 1'b1) : wordCnt_r;

	always_comb begin
		state_nxt = state_r;
		width_nxt = width_r;
		porCnt_nxt = porCnt_r;
		ratio_nxt = ratio_r;
		phase_nxt = phase_r;
		wordCnt_nxt = wordCnt_r;
		fallCnt_nxt = fallCnt_r;
		initCnt_nxt = initCnt_r;
		statusLowOe_nxt = statusLowOe_r;
		loadComplete_nxt = loadComplete_r;
		initDoneLowOe_nxt = initDoneLowOe_r;
		devDataOe_nxt = devDataOe_r;
		devData_nxt = devData_r;
		cfgWord_nxt = cfgWord_r;
		cfgWordValid_nxt = 1'b0;
		userMode_nxt = userMode_r;
		case (state_r)
			pcl_pkg::D_STRAP: begin
				case (modeSelectPins[1:0])
					2'h0: width_nxt = pcl_pkg::W8;
					2'h1: width_nxt = pcl_pkg::W16;
					default: width_nxt = pcl_pkg::W32;
				endcase
				porCnt_nxt = modeSelectPins[`PCL_STRAP_LONG_POR] ? 32'(PorLongCycles - 1)
					: 32'(PorShortCycles - 1);
				ratio_nxt = decompressEn ? `PCL_RATIO_PACKED
					: (securityEn ? `PCL_RATIO_SECURE : `PCL_RATIO_PLAIN);
				state_nxt = pcl_pkg::D_POR;
			end
			pcl_pkg::D_POR: begin
				statusLowOe_nxt = 1'b1;
				if (porCnt_r == 32'h0) begin
					state_nxt = pcl_pkg::D_HOLD;
				end else begin
					porCnt_nxt = porCnt_r - 32'h1;
				end
			end
			pcl_pkg::D_HOLD: begin
				if (reqNSync) begin
					statusLowOe_nxt = 1'b0;
					phase_nxt = 3'h0;
					wordCnt_nxt = '0;
					state_nxt = pcl_pkg::D_LOAD;
				end
			end
			pcl_pkg::D_LOAD: begin
				// paused clock simply brings no edges
				if (cclkRise) begin
					if (takeWord) begin
						cfgWord_nxt = dataSync & laneMask;
						cfgWordValid_nxt = 1'b1;
						wordCnt_nxt = cntAfter;
						if (wordCnt_r == '0 && dataSync[`PCL_OPT_INITDONE_BIT]) begin
							initDoneLowOe_nxt = 1'b1;
						end
					end
					if (3'(phase_r + 1'b1) == ratio_r[2:0] || ratio_r == 4'h8 && phase_r == 3'h7) begin
						phase_nxt = 3'h0;
						if (cntAfter == CntW'(ImageWords)) begin
							loadComplete_nxt = 1'b1;
							fallCnt_nxt = 2'h0;
							state_nxt = pcl_pkg::D_DONE;
						end
					end else begin
						phase_nxt = 3'(phase_r + 1'b1);
					end
				end
			end
			pcl_pkg::D_DONE: begin
				if (cclkFall) begin
					fallCnt_nxt = 2'(fallCnt_r + 1'b1);
					if (fallCnt_r == 2'(`PCL_FALLS_AFTER_DONE - 1)) begin
						initCnt_nxt = 8'(InitCycles - 1);
						state_nxt = pcl_pkg::D_INIT;
					end
				end
			end
			pcl_pkg::D_INIT: begin
				if (initCnt_r == 8'h0) begin
					initDoneLowOe_nxt = 1'b0;
					userMode_nxt = 1'b1;
					state_nxt = pcl_pkg::D_USER;
				end else begin
					initCnt_nxt = initCnt_r - 8'h1;
				end
			end
			pcl_pkg::D_USER: begin
				devDataOe_nxt = userPinsDrive;
				devData_nxt = userDataOut;
			end
			default: state_nxt = pcl_pkg::D_HOLD;
		endcase
		// request low restarts from any state but D_STRAP and D_POR
		if (state_r != pcl_pkg::D_STRAP && state_r != pcl_pkg::D_POR && !reqNSync) begin
			state_nxt = pcl_pkg::D_HOLD;
			statusLowOe_nxt = 1'b1;
			loadComplete_nxt = 1'b0;
			initDoneLowOe_nxt = 1'b0;
			devDataOe_nxt = 1'b0;
			userMode_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= pcl_pkg::D_STRAP;
			width_r <= pcl_pkg::W8;
			porCnt_r <= 32'h0;
			ratio_r <= `PCL_RATIO_PLAIN;
			phase_r <= 3'h0;
			wordCnt_r <= '0;
			fallCnt_r <= 2'h0;
			initCnt_r <= 8'h0;
			statusLowOe_r <= 1'b1;
			loadComplete_r <= 1'b0;
			initDoneLowOe_r <= 1'b0;
			devDataOe_r <= 1'b0;
			devData_r <= 32'h0;
			cfgWord_r <= 32'h0;
			cfgWordValid_r <= 1'b0;
			userMode_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			width_r <= width_nxt;
			porCnt_r <= porCnt_nxt;
			ratio_r <= ratio_nxt;
			phase_r <= phase_nxt;
			wordCnt_r <= wordCnt_nxt;
			fallCnt_r <= fallCnt_nxt;
			initCnt_r <= initCnt_nxt;
			statusLowOe_r <= statusLowOe_nxt;
			loadComplete_r <= loadComplete_nxt;
			initDoneLowOe_r <= initDoneLowOe_nxt;
			devDataOe_r <= devDataOe_nxt;
			devData_r <= devData_nxt;
			cfgWord_r <= cfgWord_nxt;
			cfgWordValid_r <= cfgWordValid_nxt;
			userMode_r <= userMode_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs, all registered
	assign link.statusLowOe = statusLowOe_r;
	assign link.loadComplete = loadComplete_r;
	assign link.initDoneLowOe = initDoneLowOe_r;
	assign link.devDataOe = devDataOe_r;
	assign link.devData = devData_r;
	assign cfgWord = cfgWord_r;
	assign cfgWordValid = cfgWordValid_r;
	assign userMode = userMode_r;
endmodule

/* pcl_cfg_host.sv */
// host end: drives config clock and words, software reaches it by registers
// assumes the device end on the far side of pcl_link_if
`timescale 1ns/10ps
`include "pcl_defs.svh"
module pcl_cfg_host #(
	parameter int ClkHalf = `PCL_CCLK_HALF,
	parameter int ReqCycles = `PCL_REQ_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	pcl_link_if.host link,
	input wire logic [4:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	output logic irq
);
	localparam logic [4:0] MaskOfs = `PCL_REG_IRQ_MASK;

	////////////////////////////////////////////////////////////////////
	// synchronised device answers

	logic [2:0] inSync;
	logic statusNS;
	logic doneS;
	logic initS;

	pcl_sync #(.Width(3)) uInSync (
		.clk(clk),
		.rst(rst),
		.din({link.statusN, link.loadComplete, link.initDone}),
		.dout(inSync)
	);

	assign {statusNS, doneS, initS} = inSync;

	////////////////////////////////////////////////////////////////////
	// state

	pcl_pkg::pcl_host_state_t state_r, state_nxt;
	logic [7:0] ctrl_r, ctrl_nxt;
	logic [31:0] word_r, word_nxt;
	logic wordFull_r, wordFull_nxt;
	logic busyWord_r, busyWord_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic [3:0] cyc_r, cyc_nxt;
	logic sawLow_r, sawLow_nxt;
	logic cclk_r, cclk_nxt;
	logic reqN_r, reqN_nxt;
	logic [31:0] data_r, data_nxt;
	logic dataOe_r, dataOe_nxt;
	logic [`PCL_EV_BITS-1:0] stat_r, stat_nxt, mask_r, mask_nxt, ev;
	logic [31:0] rdata_r, rdata_nxt;
	logic irq_r, irq_nxt;
	logic [3:0] ratio;
	logic [31:0] laneMask;
	logic tick;

	assign ratio = ctrl_r[`PCL_CTRL_RATIO_LO +: 4];
	assign tick = cnt_r == 8'h0;

	always_comb begin
		case (ctrl_r[`PCL_CTRL_WIDTH_LO +: 2])
			2'h0: laneMask = 32'h0000_00ff;
			2'h1: laneMask = 32'h0000_ffff;
			default: laneMask = 32'hffff_ffff;
		endcase
	end

	always_comb begin
		state_nxt = state_r;
		ctrl_nxt = ctrl_r;
		word_nxt = word_r;
		wordFull_nxt = wordFull_r;
		busyWord_nxt = busyWord_r;
		cnt_nxt = tick ? cnt_r : cnt_r - 8'h1;
		cyc_nxt = cyc_r;
		sawLow_nxt = sawLow_r;
		cclk_nxt = cclk_r;
		reqN_nxt = reqN_r;
		data_nxt = data_r;
		dataOe_nxt = dataOe_r;
		ev = '0;
		if (regWr && regAddr == 5'(`PCL_REG_CTRL)) begin
			ctrl_nxt = regWdata[7:0] & 8'hfe;
			if (regWdata[`PCL_CTRL_START] && state_r != pcl_pkg::H_LOAD) begin
				state_nxt = pcl_pkg::H_REQ;
				reqN_nxt = 1'b0;
				sawLow_nxt = 1'b0;
				cnt_nxt = 8'(ReqCycles - 1);
			end
		end
		// a word written while one waits is dropped
		if (regWr && regAddr == 5'(`PCL_REG_DATA) && !wordFull_r) begin
			word_nxt = regWdata;
			wordFull_nxt = 1'b1;
		end
		case (state_r)
			pcl_pkg::H_IDLE: cclk_nxt = 1'b0;
			pcl_pkg::H_REQ: begin
				if (!statusNS) begin
					sawLow_nxt = 1'b1;
				end
				if (tick && sawLow_r) begin
					reqN_nxt = 1'b1;
					state_nxt = pcl_pkg::H_WAIT;
				end
			end
			pcl_pkg::H_WAIT: begin
				if (statusNS) begin
					dataOe_nxt = 1'b1;
					busyWord_nxt = 1'b0;
					state_nxt = pcl_pkg::H_LOAD;
				end
			end
			pcl_pkg::H_LOAD: begin
				if (busyWord_r) begin
					if (tick) begin
						cnt_nxt = 8'(ClkHalf - 1);
						cclk_nxt = !cclk_r;
						if (cclk_r) begin
							if (cyc_r == 4'(ratio - 1'b1)) begin
								busyWord_nxt = 1'b0;
								ev[`PCL_EV_WORD] = 1'b1;
							end
							cyc_nxt = 4'(cyc_r + 1'b1);
						end
					end
				end else if (wordFull_r) begin
					// data set before the rising edge
					data_nxt = word_r & laneMask;
					wordFull_nxt = 1'b0;
					busyWord_nxt = 1'b1;
					cyc_nxt = 4'h0;
					cnt_nxt = 8'(ClkHalf - 1);
				end else if (doneS) begin
					cyc_nxt = 4'h0;
					state_nxt = pcl_pkg::H_EXTRA;
				end
				if (!statusNS) begin
					ev[`PCL_EV_ERROR] = 1'b1;
					dataOe_nxt = 1'b0;
					cclk_nxt = 1'b0;
					state_nxt = pcl_pkg::H_IDLE;
				end
			end
			pcl_pkg::H_EXTRA: begin
				if (tick) begin
					cnt_nxt = 8'(ClkHalf - 1);
					cclk_nxt = !cclk_r;
					if (cclk_r) begin
						cyc_nxt = 4'(cyc_r + 1'b1);
						if (cyc_r == 4'(`PCL_FALLS_AFTER_DONE - 1)) begin
							dataOe_nxt = 1'b0;
							ev[`PCL_EV_DONE] = 1'b1;
							state_nxt = pcl_pkg::H_RUN;
						end
					end
				end
			end
			pcl_pkg::H_RUN: begin
				cclk_nxt = 1'b0;
				if (initS && !sawLow_r) begin
					sawLow_nxt = 1'b1;
					ev[`PCL_EV_USER] = 1'b1;
				end
			end
			default: state_nxt = pcl_pkg::H_IDLE;
		endcase
		if (state_r == pcl_pkg::H_EXTRA && state_nxt == pcl_pkg::H_RUN) begin
			sawLow_nxt = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// registers and interrupt; a new event wins over a clear

	always_comb begin
		stat_nxt = stat_r;
		mask_nxt = mask_r;
		if (regWr && regAddr == 5'(`PCL_REG_IRQ_STAT)) begin
			stat_nxt = stat_r & ~regWdata[`PCL_EV_BITS-1:0];
		end
		if (regWr && regAddr == MaskOfs) begin
			mask_nxt = regWdata[`PCL_EV_BITS-1:0];
		end
		stat_nxt = stat_nxt | ev;
		irq_nxt = |(stat_nxt & mask_nxt);
		rdata_nxt = 32'h0;
		if (regRd) begin
			case (regAddr)
				5'(`PCL_REG_CTRL): rdata_nxt = {24'h0, ctrl_r};
				5'(`PCL_REG_STATUS): rdata_nxt = {27'h0, initS, doneS, statusNS,
					wordFull_r, state_r != pcl_pkg::H_IDLE && state_r != pcl_pkg::H_RUN};
				5'(`PCL_REG_IRQ_STAT): rdata_nxt = {28'h0, stat_r};
				MaskOfs: rdata_nxt = {28'h0, mask_r};
				default: rdata_nxt = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= pcl_pkg::H_IDLE;
			ctrl_r <= `PCL_CTRL_RESET;
			word_r <= 32'h0;
			wordFull_r <= 1'b0;
			busyWord_r <= 1'b0;
			cnt_r <= 8'h0;
			cyc_r <= 4'h0;
			sawLow_r <= 1'b0;
			cclk_r <= 1'b0;
			reqN_r <= 1'b1;
			data_r <= 32'h0;
			dataOe_r <= 1'b0;
			stat_r <= '0;
			mask_r <= '0;
			rdata_r <= 32'h0;
			irq_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ctrl_r <= ctrl_nxt;
			word_r <= word_nxt;
			wordFull_r <= wordFull_nxt;
			busyWord_r <= busyWord_nxt;
			cnt_r <= cnt_nxt;
			cyc_r <= cyc_nxt;
			sawLow_r <= sawLow_nxt;
			cclk_r <= cclk_nxt;
			reqN_r <= reqN_nxt;
			data_r <= data_nxt;
			dataOe_r <= dataOe_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			rdata_r <= rdata_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign link.configClock = cclk_r;
	assign link.configRequestN = reqN_r;
	assign link.hostData = data_r;
	assign link.hostDataOe = dataOe_r;
	assign regRdata = rdata_r;
	assign irq = irq_r;
endmodule

/* pcl_defs.svh */
// constants for the parallel configuration loader: timing, offsets, fields
// assumes a 100 MHz system clock on both ends
`ifndef PCL_DEFS_SVH
`define PCL_DEFS_SVH

`define PCL_CLK_MHZ 100
// power-on delays in microseconds, chosen by the strap
`define PCL_POR_SHORT_US 100
`define PCL_POR_LONG_US 4000
`define PCL_INIT_CYCLES 16
`define PCL_IMAGE_WORDS 16
// config clock half period in system cycles (80 ns period)
`define PCL_CCLK_HALF 4
`define PCL_REQ_CYCLES 16
`define PCL_FALLS_AFTER_DONE 2

// clock-to-data ratios
`define PCL_RATIO_PLAIN 4'h1
`define PCL_RATIO_SECURE 4'h4
`define PCL_RATIO_PACKED 4'h8

// strap fields: [1:0] width code, [2] long power-on delay
`define PCL_STRAP_LONG_POR 2
`define PCL_OPT_INITDONE_BIT 0

// controller register offsets
`define PCL_REG_CTRL 5'h00
`define PCL_REG_STATUS 5'h04
`define PCL_REG_DATA 5'h08
`define PCL_REG_IRQ_STAT 5'h0c
`define PCL_REG_IRQ_MASK 5'h10
`define PCL_CTRL_START 0
`define PCL_CTRL_WIDTH_LO 1
`define PCL_CTRL_RATIO_LO 4
`define PCL_CTRL_RESET 8'h10
`define PCL_EV_WORD 0
`define PCL_EV_DONE 1
`define PCL_EV_USER 2
`define PCL_EV_ERROR 3
`define PCL_EV_BITS 4

`endif

/* pcl_link_if.sv */
// link between configuration host and device: clock, data, handshake
// assumes pull-ups on the open-drain status and init-done lines
`timescale 1ns/10ps
interface pcl_link_if;
	logic configClock;
	logic [31:0] hostData;
	logic hostDataOe;
	logic [31:0] devData;
	logic devDataOe;
	logic [31:0] data;
	logic configRequestN;
	logic statusLowOe;
	logic statusN;
	logic loadComplete;
	logic initDoneLowOe;
	logic initDone;

	// wire levels from the enables; pull-ups give high when undriven
	assign data = hostDataOe ? hostData : (devDataOe ? devData : 32'h0);
	assign statusN = !statusLowOe;
	assign initDone = !initDoneLowOe;

	modport device (
		input configClock,
		input data,
		input configRequestN,
		output devData,
		output devDataOe,
		output statusLowOe,
		output loadComplete,
		output initDoneLowOe
	);

	modport host (
		output configClock,
		output hostData,
		output hostDataOe,
		output configRequestN,
		input data,
		input statusN,
		input loadComplete,
		input initDone
	);
endinterface

/* pcl_link_properties.sv */
// checker for the link joining the host and device configuration ends
// assumes 100 MHz clk, synchronous active-high rst, short sim power-on counts
`timescale 1ns/10ps
module pcl_link_properties (
	input wire logic clk,
	input wire logic rst,
	input wire logic configClock,
	input wire logic configRequestN,
	input wire logic hostDataOe,
	input wire logic devDataOe,
	input wire logic statusLowOe,
	input wire logic loadComplete,
	input wire logic initDoneLowOe
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////////////
	// power-up: status low for the first 8 cycles after reset, done low
	a_reset_status_low: assert property ($fell(rst) |-> statusLowOe [*8])
		else $error("status released too soon after reset");
	a_reset_done_low: assert property ($fell(rst) |-> !loadComplete && !devDataOe)
		else $error("load complete or data drive set after reset");

	////////////////////////////////////////////////////////////////////////////////
	// restart request; sync latency allowed for
	a_request_restart: assert property ($fell(configRequestN)
		|-> ##[1:8] (statusLowOe && !loadComplete))
		else $error("request low did not restart the device");
	a_request_holds: assert property (!configRequestN [*8] |-> statusLowOe)
		else $error("status high while request held low");
	// host leaves the link clock alone while it asks for a restart
	a_clock_quiet_req: assert property (!configRequestN |-> $stable(configClock))
		else $error("link clock moved during a restart request");

	////////////////////////////////////////////////////////////////////////////////
	// end of load and initialization
	a_done_status_ok: assert property ($rose(loadComplete) |-> !statusLowOe)
		else $error("load complete rose while status low");
	a_init_after_done: assert property ($rose(loadComplete) && initDoneLowOe
		|-> initDoneLowOe [*8])
		else $error("init-done released before the extra falls");
	// a restart also drops the pull, together with load complete
	a_init_needs_done: assert property ($fell(initDoneLowOe)
		|-> loadComplete || !configRequestN)
		else $error("init-done released without load complete");

	////////////////////////////////////////////////////////////////////////////////
	// data lines go to user logic only after configuration
	a_user_pins_after: assert property (devDataOe && configRequestN
		&& $past(configRequestN, 8) |-> loadComplete)
		else $error("device drives data lines before configuration");
	a_data_no_clash: assert property (!(hostDataOe && devDataOe))
		else $error("host and device both drive the data lines");
endmodule

/* pcl_pkg.sv */
// types shared by both ends of the parallel configuration loader
// assumes pcl_defs.svh for numeric constants
package pcl_pkg;

	typedef enum logic [1:0] {
		W8,
		W16,
		W32
	} pcl_width_t;

	typedef enum {
		D_STRAP,
		D_POR,
		D_HOLD,
		D_LOAD,
		D_DONE,
		D_INIT,
		D_USER
	} pcl_dev_state_t;

	typedef enum {
		H_IDLE,
		H_REQ,
		H_WAIT,
		H_LOAD,
		H_EXTRA,
		H_RUN
	} pcl_host_state_t;

endpackage

/* pcl_sync.sv */
// two-flop synchroniser for pins from outside the clock domain
// assumes each bit is an independent level; words need stability upstream
`timescale 1ns/10ps
module pcl_sync #(
	parameter int Width = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [Width-1:0] din,
	output logic [Width-1:0] dout
);
	logic [Width-1:0] meta_r;
	logic [Width-1:0] sync_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= din;
			sync_r <= meta_r;
		end
	end

	assign dout = sync_r;
endmodule

/* tb_top.sv */
// self-checking bench: host and device ends joined by the link interface
// assumes software access through the host register port only
`timescale 1ns/10ps
module tb_top;
	localparam int Words = 4;
	logic clk, rst, regWr, regRd, decompressEn, securityEn, irq, cfgWordValid, userMode;
	logic [2:0] modeSelectPins;
	logic [4:0] regAddr;
	logic [31:0] regWdata, regRdata, cfgWord, rv;
	logic [31:0] capWord [Words];
	logic prevClk;
	int failures, total_checks, nWords, nRises, cycles;
	// straps per run: width/por code, decompress, secure, ratio
	logic [2:0] msTab [4] = '{3'b000, 3'b001, 3'b110, 3'b010};
	logic [1:0] encTab [4] = '{2'b00, 2'b01, 2'b10, 2'b11};
	logic [3:0] ratTab [4] = '{4'h1, 4'h4, 4'h8, 4'h8};

	pcl_link_if pcl_link_if_i ();
	pcl_cfg_device #(.ImageWords(Words), .PorShortCycles(20), .PorLongCycles(40),
		.InitCycles(16)) pcl_cfg_device_i (.clk(clk), .rst(rst), .link(pcl_link_if_i),
		.modeSelectPins(modeSelectPins), .decompressEn(decompressEn),
		.securityEn(securityEn), .userPinsDrive(1'b1), .userDataOut(32'ha5a5_0f0f),
		.cfgWord(cfgWord), .cfgWordValid(cfgWordValid), .userMode(userMode));
	pcl_cfg_host pcl_cfg_host_i (.clk(clk), .rst(rst), .link(pcl_link_if_i),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .irq(irq));
	pcl_link_properties pcl_link_properties_i (.clk(clk), .rst(rst),
		.configClock(pcl_link_if_i.configClock), .configRequestN(pcl_link_if_i.configRequestN),
		.hostDataOe(pcl_link_if_i.hostDataOe), .devDataOe(pcl_link_if_i.devDataOe),
		.statusLowOe(pcl_link_if_i.statusLowOe), .loadComplete(pcl_link_if_i.loadComplete),
		.initDoneLowOe(pcl_link_if_i.initDoneLowOe));

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// word taps and link clock rises seen during a load
	always @(posedge clk) begin
		prevClk <= pcl_link_if_i.configClock;
		if (cfgWordValid && nWords < Words) capWord[nWords] <= cfgWord;
		if (cfgWordValid) nWords <= nWords + 1;
		if (pcl_link_if_i.configClock && !prevClk && !pcl_link_if_i.loadComplete)
			nRises <= nRises + 1;
	end

	// hang guard; a full run needs under two thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			failures++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_sim();
		if (failures == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask

	task automatic poll(input logic [31:0] m, input logic [31:0] e);
		int n;
		n = 0;
		rd(5'h04, rv);
		while ((rv & m) !== e && n < 3000) begin
			rd(5'h04, rv);
			n++;
		end
		chk("status wait", rv & m, e);
	endtask

	function automatic logic [31:0] word(input int i);
		// bit0 set in the first word enables the init-done pin
		return 32'hc3a5_96e1 + i * 32'h0101_0100;
	endfunction

	task automatic reset_dut(input int k);
		@(posedge clk);
		modeSelectPins <= msTab[k];
		decompressEn <= encTab[k][1];
		securityEn <= encTab[k][0];
		rst <= 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (30) @(posedge clk);
		chk("por status", pcl_link_if_i.statusN, {31'h0, !msTab[k][2]});
	endtask

	task automatic load(input int k);
		logic [31:0] lanes;
		lanes = (msTab[k][1:0] == 2'd0) ? 32'hff : (msTab[k][1:0] == 2'd1) ? 32'hffff : '1;
		nWords = 0;
		nRises = 0;
		wr(5'h00, {24'h0, ratTab[k], 1'b0, msTab[k][1:0], 1'b1});
		poll(32'h4, 32'h0);
		poll(32'h4, 32'h4);
		for (int i = 0; i < Words; i++) begin
			poll(32'h2, 32'h0);
			if (i == 2) chk("init low", pcl_link_if_i.initDone, 1'b0);
			if (i == 2) chk("done low", pcl_link_if_i.loadComplete, 1'b0);
			wr(5'h08, word(i));
		end
		poll(32'h1c, 32'h1c);
		chk("words", nWords, Words);
		chk("rises", nRises, Words * ratTab[k]);
		for (int i = 0; i < Words; i++)
			chk("word", capWord[i], word(i) & lanes);
		chk("user mode", userMode, 1'b1);
		chk("user data", pcl_link_if_i.data, 32'ha5a5_0f0f);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = '0;
		regWdata = '0;
		modeSelectPins = '0;
		decompressEn = 1'b0;
		securityEn = 1'b0;
		for (int k = 0; k < 4; k++) begin
			reset_dut(k);
			rd(5'h00, rv);
			chk("ctrl reset", rv, 32'h10);
			rd(5'h14, rv);
			chk("unmapped", rv, 32'h0);
			wr(5'h10, 32'hf);
			load(k);
			chk("irq set", irq, 1'b1);
			rd(5'h0c, rv);
			chk("events", rv & 32'hf, 32'h7);
			wr(5'h0c, 32'hf);
			rd(5'h0c, rv);
			chk("events clear", rv, 32'h0);
			chk("irq clear", irq, 1'b0);
		end
		// masked restart from user mode
		wr(5'h10, 32'h0);
		load(3);
		chk("irq masked", irq, 1'b0);
		wr(5'h10, 32'h2);
		rd(5'h04, rv);
		chk("irq unmasked", irq, 1'b1);
		end_sim();
	end
endmodule
